// *** rtl/cve_encoder.sv ***
`default_nettype none

package cve_pkg;
    localparam int CONSTRAINT_LEN = 7;
    localparam int SR_LEN = CONSTRAINT_LEN - 1;
    localparam int MAX_CODES = 7;
    localparam int MIN_CODES = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 1;
    localparam int LEVEL_W = 4;
    // Generator codes, octal 171 133 165 117 127 155 145; MSB taps the newest bit
    localparam logic [MAX_CODES-1:0][CONSTRAINT_LEN-1:0] GEN_CODE = {
        7'h65, 7'h6d, 7'h57, 7'h4f, 7'h75, 7'h5b, 7'h79
    };
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_WINDOW = 3'h2;
    localparam logic [2:0] REG_COUNT = 3'h3;
    localparam logic [2:0] REG_CONFIG = 3'h4;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_EMPTY_BIT = 4;
    localparam int STAT_FULL_BIT = 5;
    localparam int STAT_VOUT_BIT = 6;
    localparam int STAT_RUN_BIT = 7;
    localparam int CFG_CODES_LSB = 0;
    localparam int CFG_LEN_LSB = 4;

    typedef struct packed {
        logic [SR_LEN-1:0] sr;
        logic enable;
        logic [MAX_CODES-1:0] coded;
        logic vout;
        logic [31:0] bit_count;
        logic wait_req;
        logic [31:0] rdata;
    } cve_state_type;
endpackage : cve_pkg

module cve_encoder #(
    parameter int NUM_CODES = 2
) (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic DIN_IN,
    input wire logic VIN_IN,
    output logic DIN_READY_OUT,
    input wire logic ENABLE_IN,
    output logic CODED_OUT_FIRST_OUT,
    output logic CODED_OUT_SECOND_OUT,
    output logic [cve_pkg::MAX_CODES-3:0] CODED_OUT_REST_OUT,
    output logic COUT_VALID_OUT,
    input wire logic COUT_READY_IN,
    input wire logic [2:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT
);
    localparam logic [31:0] RATE_STEP = 32'(NUM_CODES);

    cve_pkg::cve_state_type st;
    cve_pkg::cve_state_type next_st;
    logic fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [cve_pkg::LEVEL_W-1:0] fifo_level;
    logic [cve_pkg::CONSTRAINT_LEN-1:0] window;
    logic [cve_pkg::MAX_CODES-1:0] tap_bits;
    logic run;
    logic clear;
    logic req;
    logic [31:0] rd_value;

    // Input bits queue here; a stalled decoder backs up to the source
    cve_fifo #(
        .WIDTH(cve_pkg::FIFO_WIDTH),
        .DEPTH(cve_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_data_in(DIN_IN),
        .wr_valid_in(VIN_IN),
        .wr_ready_out(DIN_READY_OUT),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop),
        .level_out(fifo_level)
    );

    // Newest bit at the top of the window
    assign window = {fifo_data, st.sr};

    // Codes are constants, so unused taps fold away in synthesis
    for (genvar i = 0; i < cve_pkg::MAX_CODES; i++) begin : g_tap
        if (i < NUM_CODES) begin : g_used
            assign tap_bits[i] = ^(window & cve_pkg::GEN_CODE[i]);
            a_code_sum: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
                fifo_pop |=> st.coded[i] == ^($past(window) & cve_pkg::GEN_CODE[i]))
                else $error("coded bit uses wrong taps");
        end else begin : g_unused
            assign tap_bits[i] = 1'b0;
            a_unused_tap: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
                st.coded[i] == 1'b0)
                else $error("unused coded bit not zero");
        end
    end

    assign req = AVS_READ_IN || AVS_WRITE_IN;
    assign clear = AVS_WRITE_IN && !st.wait_req && (AVS_ADDRESS_IN == cve_pkg::REG_CTRL)
        && AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[cve_pkg::CTRL_CLEAR_BIT];
    assign run = st.enable && ENABLE_IN;
    // Holding the output while unread keeps coded bits from being dropped
    assign fifo_pop = run && fifo_valid && !clear && (!st.vout || COUT_READY_IN);

    always_comb begin
        rd_value = 32'h0;
        if (AVS_ADDRESS_IN == cve_pkg::REG_CTRL) begin
            rd_value[cve_pkg::CTRL_ENABLE_BIT] = st.enable;
        end else if (AVS_ADDRESS_IN == cve_pkg::REG_STATUS) begin
            rd_value[cve_pkg::STAT_LEVEL_LSB +: cve_pkg::LEVEL_W] = fifo_level;
            rd_value[cve_pkg::STAT_EMPTY_BIT] = !fifo_valid;
            rd_value[cve_pkg::STAT_FULL_BIT] = !DIN_READY_OUT;
            rd_value[cve_pkg::STAT_VOUT_BIT] = st.vout;
            rd_value[cve_pkg::STAT_RUN_BIT] = run;
        end else if (AVS_ADDRESS_IN == cve_pkg::REG_WINDOW) begin
            rd_value[cve_pkg::SR_LEN-1:0] = st.sr;
        end else if (AVS_ADDRESS_IN == cve_pkg::REG_COUNT) begin
            rd_value = st.bit_count;
        end else if (AVS_ADDRESS_IN == cve_pkg::REG_CONFIG) begin
            rd_value[cve_pkg::CFG_CODES_LSB +: 3] = 3'(NUM_CODES);
            rd_value[cve_pkg::CFG_LEN_LSB +: 4] = 4'(cve_pkg::CONSTRAINT_LEN);
        end
    end

    always_comb begin
        next_st = st;
        // One wait cycle per request, then a single acknowledge cycle
        next_st.wait_req = !(req && st.wait_req);
        if (AVS_READ_IN && st.wait_req) begin
            next_st.rdata = rd_value;
        end
        if (AVS_WRITE_IN && !st.wait_req && AVS_ADDRESS_IN == cve_pkg::REG_CTRL
            && AVS_BYTEENABLE_IN[0]) begin
            next_st.enable = AVS_WRITEDATA_IN[cve_pkg::CTRL_ENABLE_BIT];
        end
        if (st.vout && COUT_READY_IN) begin
            next_st.vout = 1'b0;
        end
        if (clear) begin
            next_st.sr = '0;
            next_st.vout = 1'b0;
        end else if (fifo_pop) begin
            next_st.sr = window[cve_pkg::CONSTRAINT_LEN-1:1];
            next_st.coded = tap_bits;
            next_st.vout = 1'b1;
            next_st.bit_count = st.bit_count + RATE_STEP;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st <= '0;
            st.enable <= cve_pkg::CTRL_ENABLE_RESET;
            st.wait_req <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign CODED_OUT_FIRST_OUT = st.coded[0];
    assign CODED_OUT_SECOND_OUT = st.coded[1];
    assign CODED_OUT_REST_OUT = st.coded[cve_pkg::MAX_CODES-1:2];
    assign COUT_VALID_OUT = st.vout;
    assign AVS_READDATA_OUT = st.rdata;
    assign AVS_WAITREQUEST_OUT = st.wait_req;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (RST_IN);

    a_code_count: assert property (NUM_CODES >= cve_pkg::MIN_CODES && NUM_CODES <= cve_pkg::MAX_CODES)
        else $error("code count outside two to seven");

    a_first_sum: assert property (fifo_pop && !clear |=>
        CODED_OUT_FIRST_OUT == ^($past(window) & cve_pkg::GEN_CODE[0]))
        else $error("first coded bit is not the tap sum");

    a_second_sum: assert property (fifo_pop && !clear |=>
        CODED_OUT_SECOND_OUT == ^($past(window) & cve_pkg::GEN_CODE[1]))
        else $error("second coded bit uses wrong taps");

    a_window_shift: assert property (fifo_pop && !clear |=>
        st.sr == {$past(fifo_data), $past(st.sr[cve_pkg::SR_LEN-1:1])})
        else $error("window did not shift by one");

    a_clear_zero: assert property (clear |=> st.sr == '0 && !COUT_VALID_OUT)
        else $error("clear left shift register set");

    a_clear_no_pop: assert property (clear |-> !fifo_pop)
        else $error("bit accepted during a clear");

    a_rate_count: assert property (fifo_pop && !clear |=> st.bit_count == $past(st.bit_count) + RATE_STEP)
        else $error("coded bit count off rate");

    a_only_valid: assert property (!$stable(st.sr) |-> $past(fifo_pop) || $past(clear))
        else $error("window moved without accepted bit");

    a_unused_zero: assert property (NUM_CODES < cve_pkg::MAX_CODES |->
        st.coded[cve_pkg::MAX_CODES-1] == 1'b0)
        else $error("unused output not zero");

    a_valid_hold: assert property (COUT_VALID_OUT && !COUT_READY_IN |=>
        COUT_VALID_OUT && $stable(st.coded))
        else $error("coded output dropped before taken");

    a_one_clock: assert property (fifo_pop |=> COUT_VALID_OUT
        && st.sr[cve_pkg::SR_LEN-1] == $past(fifo_data))
        else $error("coded output not one clock after acceptance");

    a_disabled_hold: assert property (!run |=> $stable(st.sr) && $stable(st.bit_count))
        else $error("disabled encoder moved");

    a_bus_answer: assert property (req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
        else $error("bus answer not in one cycle");

    // Decoder side: an unread word blocks the next pop
    a_valid_drop: assert property (COUT_VALID_OUT && COUT_READY_IN && !fifo_pop |=>
        !COUT_VALID_OUT)
        else $error("taken output still marked valid");

    a_stall_no_pop: assert property (COUT_VALID_OUT && !COUT_READY_IN |-> !fifo_pop)
        else $error("new bit accepted over an unread output");

    a_coded_hold: assert property (!fifo_pop |=> $stable(st.coded))
        else $error("coded bits changed without a new input");

    // Input side
    a_ready_level: assert property (DIN_READY_OUT == (int'(fifo_level) != cve_pkg::FIFO_DEPTH))
        else $error("input ready disagrees with queue level");

    a_level_bound: assert property (int'(fifo_level) <= cve_pkg::FIFO_DEPTH)
        else $error("queue level beyond depth");

    a_pop_has_data: assert property (fifo_pop |-> fifo_valid)
        else $error("bit taken from an empty queue");

    a_sr_hold: assert property (!fifo_pop && !clear |=> $stable(st.sr))
        else $error("window moved with no accepted bit");

    a_count_hold: assert property (!fifo_pop |=> $stable(st.bit_count))
        else $error("coded bit count moved without input");

    // Both enables must be on before a bit leaves the queue
    a_enable_pin: assert property (!ENABLE_IN |-> !fifo_pop)
        else $error("bit accepted while enable pin low");

    a_soft_enable: assert property (!st.enable |-> !fifo_pop)
        else $error("bit accepted while control enable off");

    a_ctrl_write: assert property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT
        && AVS_ADDRESS_IN == cve_pkg::REG_CTRL && AVS_BYTEENABLE_IN[0]
        |=> st.enable == $past(AVS_WRITEDATA_IN[cve_pkg::CTRL_ENABLE_BIT]))
        else $error("control write did not land");

    a_other_write: assert property (!(AVS_WRITE_IN && AVS_ADDRESS_IN == cve_pkg::REG_CTRL) |=> $stable(st.enable))
        else $error("enable changed without a control write");

    // Register bus
    a_read_data: assert property (AVS_READ_IN && AVS_WAITREQUEST_OUT |=>
        AVS_READDATA_OUT == $past(rd_value))
        else $error("read data not the addressed register");

    a_unmapped_read: assert property (AVS_READ_IN && AVS_WAITREQUEST_OUT
        && AVS_ADDRESS_IN > cve_pkg::REG_CONFIG |=> AVS_READDATA_OUT == 32'h0)
        else $error("unmapped address read nonzero");

    a_rdata_stands: assert property (!(AVS_READ_IN && AVS_WAITREQUEST_OUT) |=> $stable(AVS_READDATA_OUT))
        else $error("read data changed outside a read");

    a_wait_pulse: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low for more than one cycle");

    a_bus_idle: assert property (!req |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low with no request");

endmodule : cve_encoder

`default_nettype wire

// *** rtl/cve_fifo.sv ***
`default_nettype none

module cve_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [$clog2(DEPTH+1)-1:0] level_out
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic full;
        logic empty;
        logic room;
    } cve_fifo_state_type;

    cve_fifo_state_type st;
    cve_fifo_state_type next_st;
    logic push;
    logic pop;

    always_comb begin
        next_st = st;
        push = wr_valid_in && !st.full;
        pop = rd_ready_in && !st.empty;
        if (push) begin
            next_st.mem[st.wr_ptr] = wr_data_in;
            next_st.wr_ptr = (st.wr_ptr == LAST_SLOT) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == LAST_SLOT) ? '0 : st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
        // Flags registered so the ready seen upstream is a clean flop
        next_st.full = (next_st.count == FULL_COUNT);
        next_st.empty = (next_st.count == '0);
        next_st.room = (next_st.count != FULL_COUNT);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
            st.empty <= 1'b1;
            st.room <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign wr_ready_out = st.room;
    assign rd_valid_out = !st.empty;
    assign rd_data_out = st.mem[st.rd_ptr];
    assign level_out = st.count;

    a_fifo_flags: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.full == (st.count == FULL_COUNT)) && (st.empty == (st.count == '0)) && (st.room == !st.full))
        else $error("fifo flags disagree with count");
    a_fifo_nopush: assert property (@(posedge clk_in) disable iff (rst_in)
        st.full && !pop |=> st.count == FULL_COUNT && st.wr_ptr == $past(st.wr_ptr))
        else $error("fifo accepted data while full");

endmodule : cve_fifo

`default_nettype wire

// *** tb/cve_sink.sv ***
`default_nettype none
module cve_sink (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic stall_in,
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Ready may drop while a word waits; the encoder must hold it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= !stall_in;
        end
    end
endmodule : cve_sink
`default_nettype wire

// *** tb/cve_encoder_tb.sv ***
`default_nettype none
module cve_encoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NC = 3;
    logic clk = 0, rst = 1, din = 0, vin = 0, en = 1, stall = 0, slow = 1, rdy;
    logic rd = 0, wr = 0, c1, c2, vout, dready, wreq;
    logic [2:0] adr = 3'h0;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [cve_pkg::MAX_CODES-3:0] rest;
    logic [7:0] lf = 8'h33;
    logic [5:0] sr = 6'h0, snap;
    logic [6:0] exp_q[$];
    int err_total = 0, num_checks = 0, nbits = 0;

    always #25 clk = ~clk;

    cve_encoder #(.NUM_CODES(NC)) dut_u (.MCLK_IN(clk), .RST_IN(rst), .DIN_IN(din), .VIN_IN(vin),
        .DIN_READY_OUT(dready), .ENABLE_IN(en), .CODED_OUT_FIRST_OUT(c1), .CODED_OUT_SECOND_OUT(c2),
        .CODED_OUT_REST_OUT(rest), .COUT_VALID_OUT(vout), .COUT_READY_IN(rdy), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq));
    cve_sink sink_u (.clk_in(clk), .rst_in(rst), .stall_in(stall), .ready_out(rdy));

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic hang();
        err_total++;
        $display("Error %0t: timeout", $time);
        report_and_stop();
    endtask : hang

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            if (wreq === 1'b0) begin
                q = rdat;
                rd <= 1'b0;
                wr <= 1'b0;
                // Idle edge so a following call never reassigns in this step
                @(posedge clk);
                return;
            end
        end
        hang();
    endtask : bus

    task automatic push(input logic b);
        logic [6:0] e;
        e = 7'h0;
        din <= b;
        vin <= 1'b1;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            if (dready === 1'b1) begin
                for (int k = 0; k < NC; k++) e[k] = ^({b, sr} & cve_pkg::GEN_CODE[k]);
                exp_q.push_back(e);
                sr = {b, sr[5:1]};
                nbits++;
                return;
            end
        end
        hang();
    endtask : push

    task automatic drain();
        vin <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            if (exp_q.size() == 0) return;
        end
        hang();
    endtask : drain

    always @(posedge clk) begin
        lf <= lfsr(lf);
        stall <= lf[0] & slow;
    end

    // Words are compared where they are taken, in order of acceptance
    always @(negedge clk) begin
        if (!rst && vout === 1'b1 && rdy === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0, "extra word");
            else check({rest, c2, c1}, exp_q.pop_front(), "coded word");
        end
    end

    initial begin
        #(50 * 20000);
        hang();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({dready, vout, wreq, c1, c2, rest}, 32'h280, "reset outputs");
        @(posedge clk);
        bus(1'b0, cve_pkg::REG_CONFIG, 32'h0);
        check(q, 32'h73, "config");
        bus(1'b0, 3'h5, 32'h0);
        check(q, 32'h0, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 60; i++) begin
            push(lf[3]);
            if (lf[5]) begin
                vin <= 1'b0;
                @(posedge clk);
            end
        end
        drain();
        bus(1'b0, cve_pkg::REG_WINDOW, 32'h0);
        check(q, {26'h0, sr}, "window");
        bus(1'b0, cve_pkg::REG_COUNT, 32'h0);
        check(q, nbits * NC, "count");
        $display("test stream done");
        slow <= 1'b0;
        snap = sr;
        en <= 1'b0;
        for (int i = 0; i < 8; i++) push(lf[2]);
        vin <= 1'b0;
        bus(1'b0, cve_pkg::REG_STATUS, 32'h0);
        check(q, 32'h28, "full while off");
        bus(1'b0, cve_pkg::REG_WINDOW, 32'h0);
        check(q, {26'h0, snap}, "held window");
        fork
            begin
                repeat (6) @(posedge clk);
                en <= 1'b1;
            end
        join_none
        push(1'b1);
        drain();
        $display("test hold done");
        bus(1'b1, cve_pkg::REG_CTRL, 32'h0);
        push(1'b1);
        vin <= 1'b0;
        repeat (4) @(posedge clk);
        bus(1'b0, cve_pkg::REG_STATUS, 32'h0);
        check(q, 32'h1, "soft disable");
        bus(1'b1, cve_pkg::REG_CTRL, 32'h1);
        bus(1'b1, cve_pkg::REG_CTRL, 32'h3);
        sr = 6'h0;
        bus(1'b0, cve_pkg::REG_WINDOW, 32'h0);
        check(q, 32'h0, "cleared");
        bus(1'b0, cve_pkg::REG_CTRL, 32'h0);
        check(q, 32'h1, "ctrl");
        for (int i = 0; i < 10; i++) push(lf[4]);
        drain();
        $display("test clear done");
        report_and_stop();
    end
endmodule : cve_encoder_tb
`default_nettype wire
